// ### include/ets_pkg.sv
// Shared constants and types for the event timestamp sample slots
package ets_pkg;

  // Register byte offsets
  localparam logic [15:0] ETS_FIFTH_NANOS_OFF  = 16'h0584;
  localparam logic [15:0] ETS_FIFTH_SECS_OFF   = 16'h0588;
  localparam logic [15:0] ETS_FIFTH_PHASE_OFF  = 16'h058C;
  localparam logic [15:0] ETS_SIXTH_NANOS_OFF  = 16'h0590;
  localparam logic [15:0] ETS_SIXTH_SECS_OFF   = 16'h0594;
  localparam logic [15:0] ETS_SIXTH_PHASE_OFF  = 16'h0598;
  localparam logic [15:0] ETS_UNIT_SELECT_OFF  = 16'h05FC;

  // Field layout
  localparam int          ETS_NANOS_W          = 30;
  localparam int          ETS_POLARITY_BIT     = 30;
  localparam int          ETS_SLOT_W           = 3;
  localparam int          ETS_UNIT_SELECT_BIT  = 8;
  localparam int          ETS_UNITS            = 2;

  // Values after reset
  localparam logic [29:0] ETS_NANOS_RESET      = 30'h00000000;
  localparam logic [31:0] ETS_SECS_RESET       = 32'h00000000;
  localparam logic [2:0]  ETS_SLOT_RESET       = 3'h0;
  localparam logic        ETS_POLARITY_RESET   = 1'b0;
  localparam logic        ETS_UNIT_RESET       = 1'b0;
  localparam logic [31:0] ETS_PRDATA_RESET     = 32'h00000000;

  // Sub-period slot codes, one per 8 ns step in the 40 ns period
  localparam logic [2:0]  ETS_CODE_0NS         = 3'h0;
  localparam logic [2:0]  ETS_CODE_8NS         = 3'h1;
  localparam logic [2:0]  ETS_CODE_16NS        = 3'h2;
  localparam logic [2:0]  ETS_CODE_24NS        = 3'h3;
  localparam logic [2:0]  ETS_CODE_32NS        = 3'h4;
  localparam int          ETS_SLOT_STEP_NS     = 8;
  localparam int          ETS_SLOT_PERIOD_NS   = 40;
  localparam int          ETS_SLOTS            = ETS_SLOT_PERIOD_NS / ETS_SLOT_STEP_NS;

  typedef enum logic [2:0] {
    ETS_REG_NONE,
    ETS_REG_FIFTH_NANOS,
    ETS_REG_FIFTH_SECS,
    ETS_REG_FIFTH_PHASE,
    ETS_REG_SIXTH_NANOS,
    ETS_REG_SIXTH_SECS,
    ETS_REG_SIXTH_PHASE,
    ETS_REG_UNIT_SELECT
  } ets_reg_t;

endpackage

// ### hdl/ets_slot_store.sv
// Storage of one sample slot: banked time words, shared phase code
`timescale 1ns/10ps
module ets_slot_store
  import ets_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          wr_en,
  input  wire logic                          wr_unit,
  input  wire logic                          wr_polarity,
  input  wire logic [29:0]                   wr_nanos,
  input  wire logic [31:0]                   wr_secs,
  input  wire logic [2:0]                    wr_code,
  output logic      [ETS_UNITS-1:0]          polarity,
  output logic      [ETS_UNITS-1:0][29:0]    nanos,
  output logic      [ETS_UNITS-1:0][31:0]    secs,
  output logic      [2:0]                    code
);

  // Only the addressed bank moves on a capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity <= {ETS_UNITS{ETS_POLARITY_RESET}};
      nanos    <= {ETS_UNITS{ETS_NANOS_RESET}};
      secs     <= {ETS_UNITS{ETS_SECS_RESET}};
    end else if (wr_en) begin
      polarity[wr_unit] <= wr_polarity;
      nanos[wr_unit]    <= wr_nanos;
      secs[wr_unit]     <= wr_secs;
    end
  end

  // Phase is not banked: last capture of this slot wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code <= ETS_SLOT_RESET;
    end else if (wr_en) begin
      code <= wr_code;
    end
  end

endmodule

// ### hdl/ets_sample_slots.sv
// APB register front of the fifth and sixth event timestamp samples
`timescale 1ns/10ps
module ets_sample_slots
  import ets_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fifth_capture_valid,
  input  wire logic        fifth_capture_unit,
  input  wire logic        fifth_capture_polarity,
  input  wire logic [29:0] fifth_capture_nanos,
  input  wire logic [31:0] fifth_capture_secs,
  input  wire logic [2:0]  fifth_capture_slot,
  input  wire logic        sixth_capture_valid,
  input  wire logic        sixth_capture_unit,
  input  wire logic        sixth_capture_polarity,
  input  wire logic [29:0] sixth_capture_nanos,
  input  wire logic [31:0] sixth_capture_secs,
  input  wire logic [2:0]  sixth_capture_slot,
  output logic             unit_select
);

  logic                       setup;
  logic                       access_wr;
  ets_reg_t                   setup_reg;
  logic [31:0]                next_prdata;
  logic [2:0]                 fifth_code_in;
  logic [2:0]                 sixth_code_in;
  logic [ETS_UNITS-1:0]       fifth_polarity;
  logic [ETS_UNITS-1:0][29:0] fifth_nanos;
  logic [ETS_UNITS-1:0][31:0] fifth_secs;
  logic [2:0]                 fifth_slot;
  logic [ETS_UNITS-1:0]       sixth_polarity;
  logic [ETS_UNITS-1:0][29:0] sixth_nanos;
  logic [ETS_UNITS-1:0][31:0] sixth_secs;
  logic [2:0]                 sixth_slot;

  // Slot index 0..4 to phase code; out-of-range saturates to the last slot
  function automatic logic [2:0] ets_slot_code(input logic [2:0] idx);
    logic [2:0] c;
    c = ETS_CODE_32NS;
    unique case (idx)
      3'h0:    c = ETS_CODE_0NS;
      3'h1:    c = ETS_CODE_8NS;
      3'h2:    c = ETS_CODE_16NS;
      3'h3:    c = ETS_CODE_24NS;
      default: c = ETS_CODE_32NS;
    endcase
    return c;
  endfunction

  function automatic ets_reg_t ets_decode(input logic [15:0] addr);
    ets_reg_t r;
    r = ETS_REG_NONE;
    unique case (addr)
      ETS_FIFTH_NANOS_OFF: r = ETS_REG_FIFTH_NANOS;
      ETS_FIFTH_SECS_OFF:  r = ETS_REG_FIFTH_SECS;
      ETS_FIFTH_PHASE_OFF: r = ETS_REG_FIFTH_PHASE;
      ETS_SIXTH_NANOS_OFF: r = ETS_REG_SIXTH_NANOS;
      ETS_SIXTH_SECS_OFF:  r = ETS_REG_SIXTH_SECS;
      ETS_SIXTH_PHASE_OFF: r = ETS_REG_SIXTH_PHASE;
      ETS_UNIT_SELECT_OFF: r = ETS_REG_UNIT_SELECT;
      default:             r = ETS_REG_NONE;
    endcase
    return r;
  endfunction

  assign fifth_code_in = ets_slot_code(fifth_capture_slot);
  assign sixth_code_in = ets_slot_code(sixth_capture_slot);

  ets_slot_store u_fifth (
    .pclk        (pclk),
    .presetn     (presetn),
    .wr_en       (fifth_capture_valid),
    .wr_unit     (fifth_capture_unit),
    .wr_polarity (fifth_capture_polarity),
    .wr_nanos    (fifth_capture_nanos),
    .wr_secs     (fifth_capture_secs),
    .wr_code     (fifth_code_in),
    .polarity    (fifth_polarity),
    .nanos       (fifth_nanos),
    .secs        (fifth_secs),
    .code        (fifth_slot)
  );

  ets_slot_store u_sixth (
    .pclk        (pclk),
    .presetn     (presetn),
    .wr_en       (sixth_capture_valid),
    .wr_unit     (sixth_capture_unit),
    .wr_polarity (sixth_capture_polarity),
    .wr_nanos    (sixth_capture_nanos),
    .wr_secs     (sixth_capture_secs),
    .wr_code     (sixth_code_in),
    .polarity    (sixth_polarity),
    .nanos       (sixth_nanos),
    .secs        (sixth_secs),
    .code        (sixth_slot)
  );

  // Zero wait states: data is latched in setup, so access can end at once
  assign pready    = 1'b1;
  assign setup     = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign setup_reg = ets_decode(paddr);

  // Bank pointer; only byte lane 1 carries the select bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_select <= ETS_UNIT_RESET;
    end else if (access_wr && ets_decode(paddr) == ETS_REG_UNIT_SELECT && pstrb[1]) begin
      unit_select <= pwdata[ETS_UNIT_SELECT_BIT];
    end
  end

  always_comb begin
    next_prdata = ETS_PRDATA_RESET;
    unique case (setup_reg)
      ETS_REG_FIFTH_NANOS: begin
        next_prdata[ETS_POLARITY_BIT]  = fifth_polarity[unit_select];
        next_prdata[ETS_NANOS_W-1:0]   = fifth_nanos[unit_select];
      end
      ETS_REG_FIFTH_SECS: begin
        next_prdata                    = fifth_secs[unit_select];
      end
      ETS_REG_FIFTH_PHASE: begin
        next_prdata[ETS_SLOT_W-1:0]    = fifth_slot;
      end
      ETS_REG_SIXTH_NANOS: begin
        next_prdata[ETS_POLARITY_BIT]  = sixth_polarity[unit_select];
        next_prdata[ETS_NANOS_W-1:0]   = sixth_nanos[unit_select];
      end
      ETS_REG_SIXTH_SECS: begin
        next_prdata                    = sixth_secs[unit_select];
      end
      ETS_REG_SIXTH_PHASE: begin
        next_prdata[ETS_SLOT_W-1:0]    = sixth_slot;
      end
      ETS_REG_UNIT_SELECT: begin
        next_prdata[ETS_UNIT_SELECT_BIT] = unit_select;
      end
      ETS_REG_NONE: begin
        next_prdata = ETS_PRDATA_RESET;
      end
    endcase
  end

  // Reserved bits stay at the zero default of next_prdata
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ETS_PRDATA_RESET;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Writes to sample registers are dropped silently, not flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= (setup_reg == ETS_REG_NONE);
    end
  end

  // Assertions
  default clocking ets_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_setup(logic [15:0] off);
    psel && !penable && !pwrite && paddr == off;
  endsequence

  sequence s_write_access(logic [15:0] off);
    psel && penable && pwrite && paddr == off;
  endsequence

  sequence s_fifth_capture(logic [2:0] idx);
    fifth_capture_valid && fifth_capture_slot == idx;
  endsequence

  sequence s_sixth_capture(logic [2:0] idx);
    sixth_capture_valid && sixth_capture_slot == idx;
  endsequence

  // Coarse range only, so the check does not lean on the decoder
  sequence s_unmapped_setup;
    psel && !penable && (paddr < ETS_FIFTH_NANOS_OFF || paddr > ETS_UNIT_SELECT_OFF);
  endsequence

  a_fifth_nanos_read: assert property (
    s_read_setup(ETS_FIFTH_NANOS_OFF) |=>
      prdata == {1'b0, $past(fifth_polarity[unit_select]), $past(fifth_nanos[unit_select])})
    else $error("fifth nanoseconds read mismatch");

  a_sixth_nanos_read: assert property (
    s_read_setup(ETS_SIXTH_NANOS_OFF) |=>
      prdata == {1'b0, $past(sixth_polarity[unit_select]), $past(sixth_nanos[unit_select])})
    else $error("sixth nanoseconds read mismatch");

  a_fifth_secs_read: assert property (
    s_read_setup(ETS_FIFTH_SECS_OFF) |=> prdata == $past(fifth_secs[unit_select]))
    else $error("fifth seconds read mismatch");

  a_sixth_secs_read: assert property (
    s_read_setup(ETS_SIXTH_SECS_OFF) |=> prdata == $past(sixth_secs[unit_select]))
    else $error("sixth seconds read mismatch");

  a_bank_select_write: assert property (
    s_write_access(ETS_UNIT_SELECT_OFF) ##0 pstrb[1] |=>
      unit_select == $past(pwdata[ETS_UNIT_SELECT_BIT]))
    else $error("unit select did not follow write");

  a_capture_polarity: assert property (
    fifth_capture_valid ##1 !fifth_capture_valid ##1 s_read_setup(ETS_FIFTH_NANOS_OFF)
      ##0 (!fifth_capture_valid && unit_select == $past(fifth_capture_unit, 2)) |=>
      prdata[ETS_POLARITY_BIT] == $past(fifth_capture_polarity, 3))
    else $error("captured polarity not reported in bit 30");

  a_fifth_phase_read: assert property (
    s_read_setup(ETS_FIFTH_PHASE_OFF) |=> prdata == {29'h0, $past(fifth_slot)})
    else $error("fifth phase read mismatch");

  a_sixth_phase_read: assert property (
    s_read_setup(ETS_SIXTH_PHASE_OFF) |=> prdata == {29'h0, $past(sixth_slot)})
    else $error("sixth phase read mismatch");

  a_phase_code_legal: assert property (
    fifth_slot <= ETS_CODE_32NS && sixth_slot <= ETS_CODE_32NS)
    else $error("reserved phase code stored");

  a_third_slot_code: assert property (
    sixth_capture_valid && sixth_capture_slot == 3'h2 |=> sixth_slot == ETS_CODE_16NS)
    else $error("third slot not encoded as 010");

  a_ro_write_ignored: assert property (
    s_write_access(ETS_FIFTH_SECS_OFF) ##0 !fifth_capture_valid |=>
      $stable(fifth_secs) && !pslverr)
    else $error("write to read-only register took effect");

  a_fifth_nanos_stored: assert property (
    fifth_capture_valid |=>
      fifth_nanos[$past(fifth_capture_unit)] == $past(fifth_capture_nanos))
    else $error("fifth nanoseconds capture not stored");

  a_fifth_secs_stored: assert property (
    fifth_capture_valid |=>
      fifth_secs[$past(fifth_capture_unit)] == $past(fifth_capture_secs))
    else $error("fifth seconds capture not stored");

  a_sixth_nanos_stored: assert property (
    sixth_capture_valid |=>
      sixth_nanos[$past(sixth_capture_unit)] == $past(sixth_capture_nanos))
    else $error("sixth nanoseconds capture not stored");

  a_sixth_secs_stored: assert property (
    sixth_capture_valid |=>
      sixth_secs[$past(sixth_capture_unit)] == $past(sixth_capture_secs))
    else $error("sixth seconds capture not stored");

  a_other_bank_kept: assert property (
    fifth_capture_valid |=>
      fifth_secs[!$past(fifth_capture_unit)] == $past(fifth_secs[!fifth_capture_unit]))
    else $error("capture disturbed the other bank");

  a_sixth_polarity: assert property (
    sixth_capture_valid ##1 !sixth_capture_valid ##1 s_read_setup(ETS_SIXTH_NANOS_OFF)
      ##0 (!sixth_capture_valid && unit_select == $past(sixth_capture_unit, 2)) |=>
      prdata[ETS_POLARITY_BIT] == $past(sixth_capture_polarity, 3))
    else $error("sixth captured polarity not reported in bit 30");

  a_unit_reg_read: assert property (
    s_read_setup(ETS_UNIT_SELECT_OFF) |=> prdata == {23'h0, $past(unit_select), 8'h00})
    else $error("unit select readback mismatch");

  a_unit_strobe_gate: assert property (
    s_write_access(ETS_UNIT_SELECT_OFF) ##0 !pstrb[1] |=> $stable(unit_select))
    else $error("unit select moved without lane 1 strobe");

  a_unit_select_held: assert property (
    !(psel && penable && pwrite && paddr == ETS_UNIT_SELECT_OFF) |=> $stable(unit_select))
    else $error("unit select moved without a write");

  a_first_slot_code: assert property (
    s_fifth_capture(3'h0) |=> fifth_slot == 3'h0)
    else $error("first slot not encoded as 000");

  a_second_slot_code: assert property (
    s_sixth_capture(3'h1) |=> sixth_slot == 3'h1)
    else $error("second slot not encoded as 001");

  a_fourth_slot_code: assert property (
    s_fifth_capture(3'h3) |=> fifth_slot == 3'h3)
    else $error("fourth slot not encoded as 011");

  a_fifth_slot_code: assert property (
    s_sixth_capture(3'h4) |=> sixth_slot == 3'h4)
    else $error("fifth slot not encoded as 100");

  a_reserved_slot_clamp: assert property (
    fifth_capture_valid && fifth_capture_slot > 3'h4 |=> fifth_slot == 3'h4)
    else $error("out-of-range slot index produced a reserved code");

  a_fifth_third_slot: assert property (
    s_fifth_capture(3'h2) |=> fifth_slot == 3'h2)
    else $error("fifth third slot not encoded as 010");

  a_unmapped_error: assert property (
    s_unmapped_setup |=> pslverr)
    else $error("unmapped address without error response");

  a_unmapped_reads_zero: assert property (
    s_unmapped_setup ##0 !pwrite |=> prdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");

  a_mapped_no_error: assert property (
    psel && !penable && paddr >= ETS_FIFTH_NANOS_OFF && paddr <= ETS_SIXTH_PHASE_OFF
      && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("sample register answered with an error");

  a_nanos_top_zero: assert property (
    psel && !penable && !pwrite
      && (paddr == ETS_FIFTH_NANOS_OFF || paddr == ETS_SIXTH_NANOS_OFF)
      |=> !prdata[31])
    else $error("reserved nanoseconds bit 31 not zero");

  a_phase_top_zero: assert property (
    psel && !penable && !pwrite
      && (paddr == ETS_FIFTH_PHASE_OFF || paddr == ETS_SIXTH_PHASE_OFF)
      |=> prdata[31:3] == 29'h0)
    else $error("reserved phase bits not zero");

  a_write_keeps_prdata: assert property (
    psel && pwrite |=> $stable(prdata))
    else $error("write disturbed read data");

  a_sixth_ro_write: assert property (
    s_write_access(ETS_SIXTH_NANOS_OFF) ##0 !sixth_capture_valid |=>
      $stable(sixth_nanos) && $stable(sixth_polarity))
    else $error("write to sixth nanoseconds took effect");

endmodule

// ### tb/test_event_timestamp_sample_slots.sv
// Self-checking bench for the fifth and sixth timestamp sample slots
`timescale 1ns/10ps
module test_event_timestamp_sample_slots
  import ets_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cv [2];
  logic        cu [2];
  logic        cp [2];
  logic [29:0] cn [2];
  logic [31:0] cs [2];
  logic [2:0]  cl [2];
  logic        unit_select;
  int          err_count;
  int          tests_run;

  ets_sample_slots DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifth_capture_valid(cv[0]),
    .fifth_capture_unit(cu[0]), .fifth_capture_polarity(cp[0]),
    .fifth_capture_nanos(cn[0]), .fifth_capture_secs(cs[0]), .fifth_capture_slot(cl[0]),
    .sixth_capture_valid(cv[1]), .sixth_capture_unit(cu[1]),
    .sixth_capture_polarity(cp[1]), .sixth_capture_nanos(cn[1]),
    .sixth_capture_secs(cs[1]), .sixth_capture_slot(cl[1]), .unit_select(unit_select));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; idle edge after release so back-to-back calls never reassign
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(name, r, exp);
    chk("pslverr", {31'h0, e}, {31'h0, exp_err});
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("write pslverr", {31'h0, e}, {31'h0, exp_err});
    chk("pready", {31'h0, pready}, 32'h00000001);
  endtask

  task automatic cap(input int s, input logic u, input logic p, input logic [29:0] n,
                     input logic [31:0] sec, input logic [2:0] sl);
    cv[s] <= 1'b1;
    cu[s] <= u;
    cp[s] <= p;
    cn[s] <= n;
    cs[s] <= sec;
    cl[s] <= sl;
    @(posedge pclk);
    cv[s] <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_reset();
    rd_chk("fifth ns", ETS_FIFTH_NANOS_OFF, 32'h00000000, 1'b0);
    rd_chk("fifth s", ETS_FIFTH_SECS_OFF, 32'h00000000, 1'b0);
    rd_chk("fifth ph", ETS_FIFTH_PHASE_OFF, 32'h00000000, 1'b0);
    rd_chk("sixth ns", ETS_SIXTH_NANOS_OFF, 32'h00000000, 1'b0);
    rd_chk("sixth s", ETS_SIXTH_SECS_OFF, 32'h00000000, 1'b0);
    rd_chk("sixth ph", ETS_SIXTH_PHASE_OFF, 32'h00000000, 1'b0);
    rd_chk("unit reg", ETS_UNIT_SELECT_OFF, 32'h00000000, 1'b0);
    rd_chk("unmapped", 16'h0600, 32'h00000000, 1'b1);
    wr(16'h0600, 32'hFFFFFFFF, 1'b1);
  endtask

  // Both banks filled with opposite polarities, then read through each bank
  task automatic t_bank();
    cap(0, 1'b0, 1'b1, 30'h3FFFFFFF, 32'hFFFFFFFF, 3'h3);
    cap(0, 1'b1, 1'b0, 30'h01234567, 32'hA5A5A5A5, 3'h1);
    cap(1, 1'b1, 1'b1, 30'h2AAAAAAA, 32'h5A5A5A5A, 3'h2);
    cap(1, 1'b0, 1'b0, 30'h15555555, 32'h00000001, 3'h4);
    rd_chk("fifth ns u0", ETS_FIFTH_NANOS_OFF, 32'h7FFFFFFF, 1'b0);
    rd_chk("fifth s u0", ETS_FIFTH_SECS_OFF, 32'hFFFFFFFF, 1'b0);
    rd_chk("sixth ns u0", ETS_SIXTH_NANOS_OFF, 32'h15555555, 1'b0);
    rd_chk("sixth s u0", ETS_SIXTH_SECS_OFF, 32'h00000001, 1'b0);
    rd_chk("fifth ph", ETS_FIFTH_PHASE_OFF, 32'h00000001, 1'b0);
    rd_chk("sixth ph", ETS_SIXTH_PHASE_OFF, 32'h00000004, 1'b0);
    wr(ETS_UNIT_SELECT_OFF, 32'hFFFFFFFF, 1'b0);
    chk("unit_select", {31'h0, unit_select}, 32'h00000001);
    rd_chk("unit reg", ETS_UNIT_SELECT_OFF, 32'h00000100, 1'b0);
    rd_chk("fifth ns u1", ETS_FIFTH_NANOS_OFF, 32'h01234567, 1'b0);
    rd_chk("fifth s u1", ETS_FIFTH_SECS_OFF, 32'hA5A5A5A5, 1'b0);
    rd_chk("sixth ns u1", ETS_SIXTH_NANOS_OFF, 32'h6AAAAAAA, 1'b0);
    rd_chk("sixth s u1", ETS_SIXTH_SECS_OFF, 32'h5A5A5A5A, 1'b0);
  endtask

  // Every slot index, including the reserved range that saturates
  task automatic t_slots();
    logic [2:0] code [8];
    code = '{ETS_CODE_0NS, ETS_CODE_8NS, ETS_CODE_16NS, ETS_CODE_24NS, ETS_CODE_32NS,
              ETS_CODE_32NS, ETS_CODE_32NS, ETS_CODE_32NS};
    for (int i = 0; i < 8; i++) begin
      cap(0, 1'b0, 1'b1, 30'h00000000, 32'h00000000, 3'(i));
      cap(1, 1'b1, 1'b0, 30'h00000000, 32'h00000000, 3'(7 - i));
      rd_chk("fifth code", ETS_FIFTH_PHASE_OFF, {29'h0, code[i]}, 1'b0);
      rd_chk("sixth code", ETS_SIXTH_PHASE_OFF, {29'h0, code[7 - i]}, 1'b0);
    end
  endtask

  // Writes of all ones must leave every sample word as it was
  task automatic t_readonly();
    logic [15:0] offs [6];
    logic [31:0] exp  [6];
    offs = '{ETS_FIFTH_NANOS_OFF, ETS_FIFTH_SECS_OFF, ETS_FIFTH_PHASE_OFF,
             ETS_SIXTH_NANOS_OFF, ETS_SIXTH_SECS_OFF, ETS_SIXTH_PHASE_OFF};
    exp  = '{32'h00000000, 32'h00000000, 32'h00000004,
             32'h00000000, 32'h00000000, 32'h00000000};
    cap(0, 1'b1, 1'b0, 30'h00000000, 32'h00000000, 3'h4);
    cap(1, 1'b1, 1'b0, 30'h00000000, 32'h00000000, 3'h0);
    for (int i = 0; i < 6; i++) wr(offs[i], 32'hFFFFFFFF, 1'b0);
    for (int i = 0; i < 6; i++) rd_chk("ro word", offs[i], exp[i], 1'b0);
  endtask

  // Strobe gate, then a mid-run reset clears banks and pointer
  task automatic t_midreset();
    pstrb <= 4'hD;
    wr(ETS_UNIT_SELECT_OFF, 32'h00000000, 1'b0);
    chk("strobe gate", {31'h0, unit_select}, 32'h00000001);
    pstrb <= 4'hF;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("unit after reset", {31'h0, unit_select}, 32'h00000000);
    rd_chk("sixth ns rst", ETS_SIXTH_NANOS_OFF, 32'h00000000, 1'b0);
    rd_chk("sixth s rst", ETS_SIXTH_SECS_OFF, 32'h00000000, 1'b0);
    cap(0, 1'b0, 1'b1, 30'h00000ABC, 32'h00000000, 3'h2);
    rd_chk("fifth edge", ETS_FIFTH_NANOS_OFF, 32'h40000ABC, 1'b0);
    cap(1, 1'b0, 1'b1, 30'h00000123, 32'h00000000, 3'h0);
    rd_chk("sixth edge", ETS_SIXTH_NANOS_OFF, 32'h40000123, 1'b0);
    wr(ETS_UNIT_SELECT_OFF, 32'h00000100, 1'b0);
    wr(ETS_UNIT_SELECT_OFF, 32'h00000000, 1'b0);
    chk("unit cleared", {31'h0, unit_select}, 32'h00000000);
  endtask

  task automatic report_and_stop();
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    err_count = 0;
    tests_run = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    for (int i = 0; i < 2; i++) begin
      {cv[i], cu[i], cp[i], cn[i], cs[i], cl[i]} = '0;
    end
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_bank();
    t_slots();
    t_readonly();
    t_midreset();
    report_and_stop();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #(100 * 5000);
    err_count++;
    report_and_stop();
  end
endmodule
